//--- cell_group_block.v
// Sixteen-cell logic block with shared controls and an APB configuration slave
`timescale 1ns/1ps
`include "cell_group_defines.vh"

module cell_group_block #(
  parameter CELLS = 16,
  parameter IDX_W = 4,
  parameter ADDR_W = 12
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [4*CELLS-1:0] data_i,
  input wire cin_i,
  input wire chain_i,
  input wire [1:0] ena_pin_i,
  input wire [1:0] ena_int_i,
  input wire [1:0] blk_clr_i,
  input wire chip_wide_clear_pin_n_i,
  input wire sclr_i,
  input wire sload_i,
  output reg [CELLS-1:0] route_a_o,
  output reg [CELLS-1:0] route_b_o,
  output reg [CELLS-1:0] local_o,
  output reg chain_o,
  output reg cout_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function is_cfg_addr;
    input [ADDR_W-1:0] a;
    begin
      is_cfg_addr = (a[ADDR_W-1:6] == `CFG_PAGE) && (a[1:0] == 2'h0);
    end
  endfunction

  function is_mapped;
    input [ADDR_W-1:0] a;
    input wr;
    begin
      is_mapped = is_cfg_addr(a) || (a == `OFS_CTRL) ||
                  (!wr && ((a == `OFS_STATUS) || (a == `OFS_Q_VEC) || (a == `OFS_LUT_VEC)));
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin filters: three stages, a change counts when stages two and three agree
  // ----------------------------------------------------------------
  wire [2:0] pin_raw = {ena_pin_i, chip_wide_clear_pin_n_i};
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_s3;
  reg [2:0] pin_filt;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pin
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          pin_s1[p] <= (p == 0) ? 1'b1 : 1'b0;
          pin_s2[p] <= (p == 0) ? 1'b1 : 1'b0;
          pin_s3[p] <= (p == 0) ? 1'b1 : 1'b0;
          pin_filt[p] <= (p == 0) ? 1'b1 : 1'b0;
        end else begin
          pin_s1[p] <= pin_raw[p];
          pin_s2[p] <= pin_s1[p];
          pin_s3[p] <= pin_s2[p];
          if (pin_s2[p] == pin_s3[p]) begin
            pin_filt[p] <= pin_s3[p];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Block control register and shared control lines
  // ----------------------------------------------------------------
  reg [31:0] ctrl;
  wire chip_clr = ctrl[`CTRL_CHIP_CLR_EN] & ~pin_filt[0];
  // Enable source per block clock: filtered pin or internal logic
  wire ena0 = ctrl[`CTRL_ENA0_SRC] ? ena_int_i[0] : pin_filt[1];
  wire ena1 = ctrl[`CTRL_ENA1_SRC] ? ena_int_i[1] : pin_filt[2];
  wire [1:0] blk_ena = {ena1, ena0};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire access = psel_i & penable_i;
  wire first_access = access & ~pready_o;
  wire commit = access & pready_o;
  wire mapped = is_mapped(paddr_i, pwrite_i);
  wire cfg_hit = is_cfg_addr(paddr_i);
  wire cfg_wr = commit & pwrite_i & cfg_hit;
  wire ctrl_wr = commit & pwrite_i & (paddr_i == `OFS_CTRL);
  wire [31:0] cfg_rd;
  wire [32*CELLS-1:0] cfg_all;
  wire [CELLS-1:0] q_vec;
  wire [CELLS-1:0] lut_vec;
  reg [31:0] next_prdata;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl <= {29'h00000000, pwdata_i[2:0]};
    end
  end

  // Config store read data is registered, hence the one wait state on every access
  always @* begin
    next_prdata = 32'h00000000;
    if (!pwrite_i) begin
      if (cfg_hit) begin
        next_prdata = cfg_rd;
      end else if (paddr_i == `OFS_CTRL) begin
        next_prdata = ctrl;
      end else if (paddr_i == `OFS_STATUS) begin
        next_prdata = {28'h0000000, blk_ena, ~pin_filt[0], chip_clr};
      end else if (paddr_i == `OFS_Q_VEC) begin
        next_prdata = {{(32-CELLS){1'b0}}, q_vec};
      end else if (paddr_i == `OFS_LUT_VEC) begin
        next_prdata = {{(32-CELLS){1'b0}}, lut_vec};
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= first_access;
      if (first_access) begin
        pslverr_o <= ~mapped;
        prdata_o <= next_prdata;
      end else if (commit) begin
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
      end
    end
  end

  cfg_store #(
    .WORDS(CELLS),
    .IDX_W(IDX_W)
  ) u_cfg (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(cfg_wr),
    .wr_idx_i(paddr_i[IDX_W+1:2]),
    .wr_data_i(pwdata_i),
    .rd_idx_i(paddr_i[IDX_W+1:2]),
    .rd_data_o(cfg_rd),
    .all_o(cfg_all)
  );

  // ----------------------------------------------------------------
  // Cell array with carry and register chains
  // ----------------------------------------------------------------
  wire [CELLS:0] carry;
  wire [CELLS:0] chain;
  wire [CELLS-1:0] ra;
  wire [CELLS-1:0] rb;
  wire [CELLS-1:0] lo;

  assign carry[0] = cin_i;
  assign chain[0] = chain_i;

  genvar c;
  generate
    for (c = 0; c < CELLS; c = c + 1) begin : g_cell
      logic_cell u_cell (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg_all[32*c +: 32]),
        .data_i(data_i[4*c +: 4]),
        .cin_i(carry[c]),
        .chain_i(chain[c]),
        .ena_i(blk_ena),
        .blk_clr_i(blk_clr_i),
        .chip_clr_i(chip_clr),
        .sclr_i(sclr_i),
        .sload_i(sload_i),
        .route_a_o(ra[c]),
        .route_b_o(rb[c]),
        .local_o(lo[c]),
        .chain_o(chain[c+1]),
        .cout_o(carry[c+1]),
        .q_o(q_vec[c]),
        .lut_o(lut_vec[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Block outputs are flopped once more, so combinational paths appear a cycle late
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      route_a_o <= {CELLS{1'b0}};
      route_b_o <= {CELLS{1'b0}};
      local_o <= {CELLS{1'b0}};
      chain_o <= 1'b0;
      cout_o <= 1'b0;
    end else begin
      route_a_o <= ra;
      route_b_o <= rb;
      local_o <= lo;
      chain_o <= chain[CELLS];
      cout_o <= carry[CELLS];
    end
  end

endmodule // cell_group_block

//--- cell_group_block_checker.sv
// Port assertions for the sixteen-cell logic block
`timescale 1ns/1ps
module cell_group_block_checker #(
  parameter CELLS = 16,
  parameter ADDR_W = 12
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [4*CELLS-1:0] data_i,
  input wire cout_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Every cell generating (d0 and d1 set) or killing the carry
  wire [4*CELLS-1:0] pm = {CELLS{4'h3}};
  wire gen = (data_i & pm) == pm;
  wire kill = ~|(data_i & pm);
  wire bad = (paddr_i[1:0] != 2'h0) || (paddr_i >= 12'h010 && paddr_i < 12'h040)
    || (paddr_i >= 12'h080);
  wire ro = pwrite_i && paddr_i >= 12'h004 && paddr_i <= 12'h00C;
  a_rdy_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_rdy_access: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
    else $error("pready outside second access cycle");
  a_rdy_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("pready not after one wait state");
  a_err_qual: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("prdata not zero when idle");
  a_err_bad: assert property (pready_o && (bad || ro) |-> pslverr_o)
    else $error("bad access not refused");
  a_cfg_ok: assert property (pready_o && !bad && paddr_i >= 12'h040 |-> !pslverr_o)
    else $error("config access refused");
  a_carry_gen: assert property (gen |=> cout_o)
    else $error("carry out low with all cells generating");
  a_carry_kill: assert property (kill |=> !cout_o)
    else $error("carry out high with all cells killing");
endmodule // cell_group_block_checker

bind cell_group_block cell_group_block_checker #(.CELLS(CELLS), .ADDR_W(ADDR_W)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .data_i(data_i), .cout_o(cout_o));

//--- cell_group_block_tb.sv
// Self-checking testbench for the sixteen-cell logic block
`timescale 1ns/1ps
module cell_group_block_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic rdy, err, chain_o, cout_o, cin, chn;
  logic [15:0] ra, rb, lo;
  logic [63:0] dreq = 64'h0, dat;
  logic creq = 0, chreq = 0, clrn = 1, sclr = 0, sload = 0;
  logic [1:0] ena = 2'h0;
  logic [1:0] enp = 2'h0;
  logic [1:0] bclr = 2'h0;
  logic [4:0] v;
  int error_cnt = 0, cmp_count = 0, n;

  always #10 clk = ~clk;

  neighbour_model i_neighbour_model (.sys_clk_i(clk), .data_req_i(dreq), .cin_req_i(creq),
    .chain_req_i(chreq), .data_o(dat), .cin_o(cin), .chain_o(chn));
  cell_group_block i_cell_group_block (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .data_i(dat), .cin_i(cin), .chain_i(chn),
    .ena_pin_i(enp), .ena_int_i(ena), .blk_clr_i(bclr), .chip_wide_clear_pin_n_i(clrn),
    .sclr_i(sclr), .sload_i(sload), .route_a_o(ra), .route_b_o(rb), .local_o(lo),
    .chain_o(chain_o), .cout_o(cout_o));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude;
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  // One APB transfer, then an idle cycle so no signal is driven twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic ee);
    int k;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      conclude;
    end
    if (!w) chk("prdata", e, prd);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task pulse(input int c);
    ena <= 2'h1;
    cyc(c);
    ena <= 2'h0;
    cyc(4);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    rst <= 1'b0;
    apb(0, 12'h000, 0, 32'h00000001, 0);
    apb(0, 12'h040, 0, 32'h00000000, 0);
    apb(0, 12'h010, 0, 0, 1);
    apb(1, 12'h004, 32'hFFFFFFFF, 0, 1);
    apb(0, 12'h042, 0, 0, 1);
    apb(1, 12'h000, 32'h00000007, 0, 0);
    apb(0, 12'h000, 0, 32'h00000007, 0);
    apb(1, 12'h040, 32'h00086996, 0, 0);
    ena <= 2'h3;
    for (v = 0; v < 16; v++) begin
      dreq[3:0] <= v[3:0];
      cyc(4);
      chk("route_a", ^v[3:0], ra[0]);
      chk("route_b", ^v[3:0], rb[0]);
      chk("local", ^v[3:0], lo[0]);
    end
    ena <= 2'h0;
    dreq[3:0] <= 4'h1;
    cyc(4);
    chk("route_a", 1, ra[0]);
    chk("route_b", 0, rb[0]);
    apb(1, 12'h040, 32'h0009FFFF, 0, 0);
    pulse(1);
    chk("toggle", 1, rb[0]);
    pulse(2);
    chk("toggle", 1, rb[0]);
    apb(1, 12'h040, 32'h00010000, 0, 0);
    apb(1, 12'h044, 32'h00210000, 0, 0);
    dreq <= 64'h44;
    ena <= 2'h1;
    sclr <= 1'b1;
    cyc(1);
    sclr <= 1'b0;
    cyc(3);
    apb(0, 12'h008, 0, 0, 0);
    sload <= 1'b1;
    cyc(1);
    sload <= 1'b0;
    cyc(3);
    apb(0, 12'h008, 0, 32'h00000001, 0);
    sload <= 1'b1;
    clrn <= 1'b0;
    cyc(8);
    clrn <= 1'b1;
    sload <= 1'b0;
    cyc(1);
    apb(0, 12'h008, 0, 0, 0);
    dreq <= {16{4'h3}};
    cyc(4);
    chk("cout", 1, cout_o);
    dreq <= {16{4'h1}};
    creq <= 1'b1;
    cyc(4);
    chk("cout", 1, cout_o);
    creq <= 1'b0;
    cyc(4);
    chk("cout", 0, cout_o);
    // Block clear beats a table that keeps driving one
    apb(1, 12'h040, 32'h1008FFFF, 0, 0);
    apb(0, 12'h008, 0, 32'h00000001, 0);
    bclr <= 2'h1;
    cyc(1);
    apb(0, 12'h008, 0, 32'h00000000, 0);
    bclr <= 2'h0;
    ena <= 2'h0;
    // Feedback: table is the inverse of the cell's own storage
    apb(1, 12'h040, 32'h004000FF, 0, 0);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000001, 0);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000000, 0);
    // JK and SR with direct data as J/S and d3 as K/R
    dreq[3:0] <= 4'hC;
    apb(1, 12'h040, 32'h04020000, 0, 0);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000001, 0);
    dreq[3:0] <= 4'h8;
    cyc(2);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000000, 0);
    dreq[3:0] <= 4'h4;
    apb(1, 12'h040, 32'h04030000, 0, 0);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000001, 0);
    dreq[3:0] <= 4'hC;
    cyc(2);
    pulse(1);
    apb(0, 12'h008, 0, 32'h00000000, 0);
    // Enables taken from the filtered pins
    enp <= 2'h1;
    apb(1, 12'h000, 32'h00000001, 0, 0);
    cyc(6);
    apb(0, 12'h004, 0, 32'h00000004, 0);
    enp <= 2'h0;
    apb(1, 12'h000, 32'h00000007, 0, 0);
    ena <= 2'h1;
    cyc(2);
    for (v = 0; v < 16; v++) apb(1, {6'h01, v[3:0], 2'h0}, 32'h02000000, 0, 0);
    chreq <= 1'b1;
    cyc(1);
    chreq <= 1'b0;
    n = 0;
    while (chain_o !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("chain_delay", 1, {31'h0, n >= 16 && n <= 20});
    conclude;
  end
endmodule // cell_group_block_tb

//--- cell_group_defines.vh
// Constants for the sixteen-cell logic block: register map, fields, reset values
//
// Overview of operation
// - Each cell has a four-input table realising any function of four inputs.
// - Cell storage behaves as D, T, JK or SR flip-flop by configuration.
// - Storage has data, clock, clock enable and clear inputs.
// - Combinational use: table result bypasses storage straight to the outputs.
// - Three general outputs, each separately selecting table result or stored value.
// - Two outputs feed row, column and direct routing; one feeds local routing.
// - In packing mode the block-wide synchronous load does not reach that cell.
// - Feedback mode routes the stored value back into the cell's own table.
// - A cell can show registered and unregistered table result at once.
// - A dedicated chain output lets storage elements cascade as a shift register.
// - Each cell's carry output drives the next cell's carry input.
// - Carry continues across blocks through block carry input and output.
// - A block groups exactly sixteen cells sharing the block control lines.
// - Clock enable comes from pins or logic; clock and clear also globally.
// - Block synchronous clear and load act on every enabled storage element, clear winning over load; load skips packed cells.
// - Deasserted block clock enable stops every storage element using that clock; block clear and chip-wide clear still act while it is low.
// - Enabled chip-wide clear clears all storage and overrides every other control.
`ifndef CELL_GROUP_DEFINES_VH
`define CELL_GROUP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_Q_VEC 12'h008
`define OFS_LUT_VEC 12'h00C
`define OFS_CFG_BASE 12'h040
`define CFG_PAGE 6'h01

// ----------------------------------------------------------------
// Block control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_CHIP_CLR_EN 0
`define CTRL_ENA0_SRC 1
`define CTRL_ENA1_SRC 2
`define CTRL_RST 32'h00000001

// ----------------------------------------------------------------
// Per-cell configuration word fields
// ----------------------------------------------------------------
`define CFG_LUT_LSB 0
`define CFG_LUT_MSB 15
`define CFG_MODE_LSB 16
`define CFG_MODE_MSB 17
`define CFG_OSEL_LSB 18
`define CFG_OSEL_MSB 20
`define CFG_PACK 21
`define CFG_FBK 22
`define CFG_CLKSEL 23
`define CFG_CLRSEL 24
`define CFG_DSEL_LSB 25
`define CFG_DSEL_MSB 26
`define CFG_CINSEL 27
`define CFG_CLREN 28
`define CFG_RST 32'h00000000

// ----------------------------------------------------------------
// Storage modes, data sources, pin filter depth
// ----------------------------------------------------------------
`define MODE_D 2'h0
`define MODE_T 2'h1
`define MODE_JK 2'h2
`define MODE_SR 2'h3
`define DSEL_LUT 2'h0
`define DSEL_CHAIN 2'h1
`define DSEL_DIRECT 2'h2
`define SYNC_STAGES 3

`endif

//--- cfg_store.v
// Configuration word store for all cells of the block
`timescale 1ns/1ps
`include "cell_group_defines.vh"

module cfg_store #(
  parameter WORDS = 16,
  parameter IDX_W = 4
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [IDX_W-1:0] wr_idx_i,
  input wire [31:0] wr_data_i,
  input wire [IDX_W-1:0] rd_idx_i,
  output reg [31:0] rd_data_o,
  output wire [32*WORDS-1:0] all_o
);

  reg [31:0] mem [0:WORDS-1];
  integer i;

  // Every word is also presented in parallel, since all cells run at once
  genvar g;
  generate
    for (g = 0; g < WORDS; g = g + 1) begin : g_flat
      assign all_o[32*g +: 32] = mem[g];
    end
  endgenerate

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem[i] <= `CFG_RST;
      end
      rd_data_o <= 32'h00000000;
    end else begin
      if (wr_en_i) begin
        mem[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule // cfg_store

//--- logic_cell.v
// One programmable logic cell: four-input table, configurable storage, chains
`timescale 1ns/1ps
`include "cell_group_defines.vh"

module logic_cell (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [31:0] cfg_i,
  input wire [3:0] data_i,
  input wire cin_i,
  input wire chain_i,
  input wire [1:0] ena_i,
  input wire [1:0] blk_clr_i,
  input wire chip_clr_i,
  input wire sclr_i,
  input wire sload_i,
  output wire route_a_o,
  output wire route_b_o,
  output wire local_o,
  output wire chain_o,
  output wire cout_o,
  output wire q_o,
  output wire lut_o
);

  reg q;
  reg d_src;
  wire [15:0] lut_mask = cfg_i[`CFG_LUT_MSB:`CFG_LUT_LSB];
  wire [1:0] mode = cfg_i[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire [2:0] osel = cfg_i[`CFG_OSEL_MSB:`CFG_OSEL_LSB];
  wire [1:0] dsel = cfg_i[`CFG_DSEL_MSB:`CFG_DSEL_LSB];
  wire top_in = cfg_i[`CFG_FBK] ? q : (cfg_i[`CFG_CINSEL] ? cin_i : data_i[3]);
  wire [3:0] lut_idx = {top_in, data_i[2:0]};
  wire lut_out = lut_mask[lut_idx];
  wire ena = ena_i[cfg_i[`CFG_CLKSEL]];
  wire clr = cfg_i[`CFG_CLREN] & blk_clr_i[cfg_i[`CFG_CLRSEL]];
  wire load_ok = sload_i & ~cfg_i[`CFG_PACK];
  // Second operand for JK (K) and SR (R) modes
  wire k_in = data_i[3];

  always @* begin
    case (dsel)
      `DSEL_CHAIN: d_src = chain_i;
      `DSEL_DIRECT: d_src = data_i[2];
      default: d_src = lut_out;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      q <= 1'b0;
    end else if (chip_clr_i) begin
      q <= 1'b0;
    end else if (clr) begin
      q <= 1'b0;
    end else if (ena) begin
      if (sclr_i) begin
        q <= 1'b0;
      end else if (load_ok) begin
        q <= data_i[2];
      end else begin
        case (mode)
          `MODE_T: q <= q ^ d_src;
          `MODE_JK: q <= (d_src & ~q) | (~k_in & q);
          `MODE_SR: q <= k_in ? 1'b0 : (d_src ? 1'b1 : q);
          default: q <= d_src;
        endcase
      end
    end
  end

  // Each output picks table or storage on its own
  assign route_a_o = osel[0] ? q : lut_out;
  assign route_b_o = osel[1] ? q : lut_out;
  assign local_o = osel[2] ? q : lut_out;
  assign chain_o = q;
  assign cout_o = (data_i[0] & data_i[1]) | (cin_i & (data_i[0] ^ data_i[1]));
  assign q_o = q;
  assign lut_o = lut_out;

endmodule // logic_cell

//--- neighbour_model.sv
// Upstream neighbour cells: registered data, carry and chain into the block
`timescale 1ns/1ps
module neighbour_model (
  input wire sys_clk_i,
  input wire [63:0] data_req_i,
  input wire cin_req_i,
  input wire chain_req_i,
  output logic [63:0] data_o,
  output logic cin_o,
  output logic chain_o
);
  // Neighbours launch from their own storage, so values move only on an edge
  always @(posedge sys_clk_i) begin
    data_o <= data_req_i;
    cin_o <= cin_req_i;
    chain_o <= chain_req_i;
  end
endmodule // neighbour_model
